/* include/ctdsc_params.svh */
`ifndef CTDSC_PARAMS_SVH
`define CTDSC_PARAMS_SVH
// Register offsets
`define CTDSC_OFF_TRIM    4'h0
`define CTDSC_OFF_DIV     4'h4
`define CTDSC_OFF_CORE    4'h8
`define CTDSC_OFF_STAT    4'hC
// Divider register fields
`define CTDSC_DIV_UNLOCK  7
`define CTDSC_UNLOCK_WORD 8'h80
`define CTDSC_DIV_MAXCODE 4'h8
// Core control register fields
`define CTDSC_CORE_ARM    5
`define CTDSC_CORE_KIND_H 4
`define CTDSC_CORE_KIND_L 3
// Reset values
`define CTDSC_SEL_RST     4'h0
`define CTDSC_SEL_RST_D8  4'h3
`define CTDSC_CORE_RST    8'h00
// Timing counts
`define CTDSC_UNLOCK_CYC  3'h4
`define CTDSC_WAKE_HALT   4'h4
`define CTDSC_STARTUP_CYC 4'h6
`define CTDSC_STANDBY_CYC 4'h6
`endif

/* include/ctdsc_pkg.sv */
package ctdsc_pkg;
  // Sleep kinds as coded in the core control register
  typedef enum logic [1:0] {
    CTDSC_IDLE     = 2'h0,
    CTDSC_ADC_QUIET = 2'h1,
    CTDSC_PWR_DOWN = 2'h2,
    CTDSC_STANDBY  = 2'h3
  } ctdsc_kind_t;
  // Power state of the core
  typedef enum logic [2:0] {
    CTDSC_ST_RUN   = 3'h1,
    CTDSC_ST_SLEEP = 3'h2,
    CTDSC_ST_WAKE  = 3'h4
  } ctdsc_state_t;
endpackage : ctdsc_pkg

/* rtl/ctdsc_top.sv */
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "ctdsc_params.svh"

// Notes on behaviour
// - Reset loads factory trim; software may rewrite
// - Trim top bit picks oscillator range
// - Lower seven trim bits tune within range
// - Unlock sets only on exact unlock word
// - Unlock clears after four cycles or select
// - Select write accepted only while unlocked
// - Divider bits 6..4 read zero, ignore writes
// - Select resets to 0 or 3 by option
// - Codes 0..8 divide by power of two
// - Divided tick paces CPU and all peripherals
// - Sleep needs sleep instruction with arm bit
// - Interrupt wake stalls four beyond start-up
// - Reset during sleep restarts from reset vector
// - Idle stops only CPU and flash clocks
// - Idle or ADC-quiet starts conversion if enabled
// - ADC-quiet stops I/O too, limited wake set
// - Power-down stops oscillator, pins or watchdog wake
// - Standby keeps oscillator, wakes in six cycles
// - Divider switches only at period boundary
module ctdsc_top #(
  parameter int SYNC_PINS = 2
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Straps, static after reset
  input  wire logic [7:0] factory_trim,
  input  wire logic       divide_by_eight_option,
  // Core and peripheral status
  input  wire logic       sleep_instr,
  input  wire logic       adc_enabled,
  input  wire logic       xtal_source,
  // Wake sources from logic on this clock
  input  wire logic       irq_pending,
  input  wire logic       adc_done_irq,
  input  wire logic       mem_ready_irq,
  input  wire logic       wdt_irq,
  // Wake sources from pins
  input  wire logic       ext_external_interrupt_zero_level,
  input  wire logic       pin_change,
  // Oscillator trim
  output logic      [7:0] osc_trim,
  output logic            trim_range_select,
  output logic      [6:0] trim_fine_value,
  // Divided clock and domain gates
  output logic            sys_tick,
  output logic            cpu_clk_on,
  output logic            flash_clk_on,
  output logic            io_clk_on,
  output logic            adc_clk_on,
  output logic            osc_run,
  // Sleep events
  output logic            adc_start,
  output logic            wake_irq_go
);

  // Only the two wake pins are wired up; other counts cannot be served
  if (SYNC_PINS != 2) begin : g_bad_sync
    $error("SYNC_PINS must be 2");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Pins are asynchronous, so each passes three flops first
  logic [1:0] pin_in;
  logic [1:0] pin_lvl;
  assign pin_in = {pin_change, ext_external_interrupt_zero_level};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_PINS; gi++) begin : g_sync
      logic s1_r, s2_r, s3_r, lvl_r, lvl_nxt;
      // Level moves only when the two later stages agree
      always_comb begin
        lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
      end
      // Only the second stage ever reads the first
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          s1_r  <= 1'b0;
          s2_r  <= 1'b0;
          s3_r  <= 1'b0;
          lvl_r <= 1'b0;
        end else begin
          s1_r  <= pin_in[gi];
          s2_r  <= s1_r;
          s3_r  <= s2_r;
          lvl_r <= lvl_nxt;
        end
      end
      assign pin_lvl[gi] = lvl_r;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Register decode
  // Unmapped offsets match nothing, so writes there are dropped
  logic wr_trim, wr_div, wr_core;
  assign wr_trim = reg_wr && (reg_addr == `CTDSC_OFF_TRIM);
  assign wr_div  = reg_wr && (reg_addr == `CTDSC_OFF_DIV);
  assign wr_core = reg_wr && (reg_addr == `CTDSC_OFF_CORE);

  ////////////////////////////////////////////////////////////////////////
  // Trim and strap capture
  logic [7:0] trim_r, trim_nxt;
  logic       boot_r, boot_nxt;
  logic [3:0] sel_r, sel_nxt;
  logic       unlock_r, unlock_nxt;
  logic [2:0] ucnt_r, ucnt_nxt;

  // Straps are read at the first edge after release, never under reset
  always_comb begin
    trim_nxt = trim_r;
    boot_nxt = 1'b0;
    if (boot_r) begin
      trim_nxt = factory_trim;
    end else if (wr_trim) begin
      trim_nxt = reg_wdata;
    end
  end

  // Unlock window and divider select
  always_comb begin
    sel_nxt    = sel_r;
    unlock_nxt = unlock_r;
    ucnt_nxt   = ucnt_r;
    if (boot_r) begin
      sel_nxt = divide_by_eight_option ? `CTDSC_SEL_RST_D8 : `CTDSC_SEL_RST;
    end
    if (unlock_r) begin
      // Window closes on its own after four cycles
      if (ucnt_r == 3'h1) begin
        unlock_nxt = 1'b0;
      end
      ucnt_nxt = ucnt_r - 3'h1;
    end
    if (wr_div) begin
      if (reg_wdata == `CTDSC_UNLOCK_WORD) begin
        // Rewrite inside the window leaves timer alone
        if (!unlock_r) begin
          unlock_nxt = 1'b1;
          ucnt_nxt   = `CTDSC_UNLOCK_CYC;
        end
      end else if (unlock_r && !reg_wdata[`CTDSC_DIV_UNLOCK]) begin
        sel_nxt    = reg_wdata[3:0];
        unlock_nxt = 1'b0;
        ucnt_nxt   = 3'h0;
      end
    end
  end

  // Trim, unlock window and select registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trim_r   <= 8'h00;
      boot_r   <= 1'b1;
      sel_r    <= `CTDSC_SEL_RST;
      unlock_r <= 1'b0;
      ucnt_r   <= 3'h0;
    end else begin
      trim_r   <= trim_nxt;
      boot_r   <= boot_nxt;
      sel_r    <= sel_nxt;
      unlock_r <= unlock_nxt;
      ucnt_r   <= ucnt_nxt;
    end
  end

  // Range bit and fine value straight from the trim register
  assign osc_trim          = trim_r;
  assign trim_range_select = trim_r[7];
  assign trim_fine_value   = trim_r[6:0];

  ////////////////////////////////////////////////////////////////////////
  // Glitch-free divider
  logic [3:0] act_r, act_nxt;
  logic [7:0] dcnt_r, dcnt_nxt;
  logic       tick_r, tick_nxt;
  logic [7:0] term;

  // Terminal count of the factor now in force
  // Codes above eight never reach act_r, so the shift stays in range
  assign term = 8'((9'h001 << act_r) - 9'h001);

  // New factor taken only at a period end, so no short period appears
  // Trade-off: a new factor waits up to one old period to apply
  always_comb begin
    act_nxt  = act_r;
    dcnt_nxt = dcnt_r + 8'h01;
    tick_nxt = 1'b0;
    if (dcnt_r >= term) begin
      dcnt_nxt = 8'h00;
      tick_nxt = 1'b1;
      // Reserved codes keep the old factor running
      if (sel_r <= `CTDSC_DIV_MAXCODE) begin
        act_nxt = sel_r;
      end
    end
  end

  // Divider state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      act_r  <= `CTDSC_SEL_RST;
      dcnt_r <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      act_r  <= act_nxt;
      dcnt_r <= dcnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign sys_tick = tick_r;

  ////////////////////////////////////////////////////////////////////////
  // Sleep controller
  logic [7:0]              core_r, core_nxt;
  ctdsc_pkg::ctdsc_state_t st_r, st_nxt;
  ctdsc_pkg::ctdsc_kind_t  kind_r, kind_nxt, kind_sel;
  logic [3:0]              halt_r, halt_nxt;
  logic                    wake_ev;
  logic                    adcs_r, adcs_nxt;
  logic                    go_r, go_nxt;
  logic [4:0]              gate_r, gate_nxt;

  // Sleep kind as software last wrote it
  assign kind_sel = ctdsc_pkg::ctdsc_kind_t'(core_r[`CTDSC_CORE_KIND_H:`CTDSC_CORE_KIND_L]);

  // Wake sources allowed in each kind
  always_comb begin
    unique case (kind_r)
      ctdsc_pkg::CTDSC_IDLE:
        wake_ev = irq_pending | adc_done_irq | mem_ready_irq | wdt_irq
                | pin_lvl[0] | pin_lvl[1];
      ctdsc_pkg::CTDSC_ADC_QUIET:
        wake_ev = adc_done_irq | mem_ready_irq | wdt_irq
                | pin_lvl[0] | pin_lvl[1];
      ctdsc_pkg::CTDSC_PWR_DOWN,
      ctdsc_pkg::CTDSC_STANDBY:
        wake_ev = wdt_irq | pin_lvl[0] | pin_lvl[1];
    endcase
  end

  // Entry, halt after wake, and clock gating
  always_comb begin
    core_nxt = wr_core ? (reg_wdata & 8'h38) : core_r;
    st_nxt   = st_r;
    kind_nxt = kind_r;
    halt_nxt = halt_r;
    adcs_nxt = 1'b0;
    go_nxt   = 1'b0;
    unique case (st_r)
      ctdsc_pkg::CTDSC_ST_RUN: begin
        if (sleep_instr && core_r[`CTDSC_CORE_ARM]) begin
          st_nxt   = ctdsc_pkg::CTDSC_ST_SLEEP;
          kind_nxt = kind_sel;
          // Standby only holds with a crystal; otherwise power down
          if (kind_sel == ctdsc_pkg::CTDSC_STANDBY && !xtal_source) begin
            kind_nxt = ctdsc_pkg::CTDSC_PWR_DOWN;
          end
          adcs_nxt = adc_enabled && !kind_sel[1];
        end
      end
      ctdsc_pkg::CTDSC_ST_SLEEP: begin
        if (wake_ev) begin
          st_nxt = ctdsc_pkg::CTDSC_ST_WAKE;
          unique case (kind_r)
            ctdsc_pkg::CTDSC_STANDBY:  halt_nxt = `CTDSC_STANDBY_CYC - 4'h1;
            ctdsc_pkg::CTDSC_PWR_DOWN: halt_nxt = `CTDSC_STARTUP_CYC + `CTDSC_WAKE_HALT - 4'h1;
            default:                   halt_nxt = `CTDSC_WAKE_HALT - 4'h1;
          endcase
        end
      end
      ctdsc_pkg::CTDSC_ST_WAKE: begin
        halt_nxt = halt_r - 4'h1;
        if (halt_r == 4'h0) begin
          st_nxt = ctdsc_pkg::CTDSC_ST_RUN;
          go_nxt = 1'b1;
        end
      end
    endcase
    // Gates: {osc, adc, io, flash, cpu}
    gate_nxt = 5'h1F;
    if (st_nxt != ctdsc_pkg::CTDSC_ST_RUN) begin
      unique case (kind_nxt)
        ctdsc_pkg::CTDSC_IDLE:      gate_nxt = 5'h1C;
        ctdsc_pkg::CTDSC_ADC_QUIET: gate_nxt = 5'h18;
        ctdsc_pkg::CTDSC_PWR_DOWN:  gate_nxt = 5'h00;
        ctdsc_pkg::CTDSC_STANDBY:   gate_nxt = 5'h10;
      endcase
      // Oscillator restarts during the wake halt
      if (st_nxt == ctdsc_pkg::CTDSC_ST_WAKE) begin
        gate_nxt[4] = 1'b1;
      end
    end
  end

  // Chip reset drops any sleep state straight back to run
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_r <= `CTDSC_CORE_RST;
      st_r   <= ctdsc_pkg::CTDSC_ST_RUN;
      kind_r <= ctdsc_pkg::CTDSC_IDLE;
      halt_r <= 4'h0;
      adcs_r <= 1'b0;
      go_r   <= 1'b0;
      gate_r <= 5'h1F;
    end else begin
      core_r <= core_nxt;
      st_r   <= st_nxt;
      kind_r <= kind_nxt;
      halt_r <= halt_nxt;
      adcs_r <= adcs_nxt;
      go_r   <= go_nxt;
      gate_r <= gate_nxt;
    end
  end

  // Domain gates, high while the domain runs
  assign cpu_clk_on   = gate_r[0];
  assign flash_clk_on = gate_r[1];
  assign io_clk_on    = gate_r[2];
  assign adc_clk_on   = gate_r[3];
  assign osc_run      = gate_r[4];
  assign adc_start    = adcs_r;
  assign wake_irq_go  = go_r;

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  logic [7:0] rd_r, rd_nxt;

  // Status packs state, kind in force and low bits of the active code
  always_comb begin
    rd_nxt = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `CTDSC_OFF_TRIM: rd_nxt = trim_r;
        `CTDSC_OFF_DIV:  rd_nxt = {unlock_r, 3'h0, sel_r};
        `CTDSC_OFF_CORE: rd_nxt = core_r;
        `CTDSC_OFF_STAT: rd_nxt = {st_r, kind_r, act_r[2:0]};
        default:         rd_nxt = 8'h00;
      endcase
    end
  end

  // Idle cycles read zero, so stale data never lingers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_r <= 8'h00;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign reg_rdata = rd_r;

endmodule : ctdsc_top
`default_nettype wire

/* bench/ctdsc_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module ctdsc_monitor (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Trim outputs
  input wire logic [7:0] osc_trim,
  input wire logic       trim_range_select,
  input wire logic [6:0] trim_fine_value,
  // Sleep side
  input wire logic       sleep_instr,
  input wire logic       adc_enabled,
  input wire logic       cpu_clk_on,
  input wire logic       flash_clk_on,
  input wire logic       io_clk_on,
  input wire logic       adc_clk_on,
  input wire logic       osc_run,
  input wire logic       adc_start,
  input wire logic       wake_irq_go
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  // Trim and divider registers
  a_trim_write_applied: assert property (reg_wr && reg_addr == 4'h0 |=> osc_trim == $past(reg_wdata))
    else $error("trim write not applied");
  a_trim_range_bit: assert property (trim_range_select == osc_trim[7])
    else $error("range bit mismatch");
  a_trim_fine_bits: assert property (trim_fine_value == osc_trim[6:0])
    else $error("fine bits mismatch");
  a_div_rsvd_zero: assert property (reg_rd && reg_addr == 4'h4 |=> reg_rdata[6:4] == 3'h0)
    else $error("divider reserved bits set");
  ////////////////////////////////////////////////////////////////
  // Gates nest: a deeper mode never runs a clock a lighter one stops
  a_cpu_flash_pair: assert property (cpu_clk_on == flash_clk_on)
    else $error("cpu and flash gates differ");
  a_io_stop_nest: assert property (!io_clk_on |-> !cpu_clk_on)
    else $error("cpu runs with io stopped");
  a_osc_stop_all: assert property (!osc_run |-> !adc_clk_on && !io_clk_on)
    else $error("clock runs with oscillator off");
  a_sleep_cause: assert property ($fell(cpu_clk_on) |-> $past(sleep_instr))
    else $error("sleep without instruction");
  a_adc_auto_start: assert property (adc_start |-> $fell(cpu_clk_on) && $past(adc_enabled) && adc_clk_on)
    else $error("adc start out of place");
  a_wake_pulse: assert property (wake_irq_go |-> (cpu_clk_on && io_clk_on && adc_clk_on && osc_run) ##1 !wake_irq_go)
    else $error("wake pulse wrong");
  a_resume_go: assert property ($rose(cpu_clk_on) |-> wake_irq_go)
    else $error("cpu resumed without wake pulse");
  a_halt_four: assert property (wake_irq_go |-> !$past(cpu_clk_on, 4))
    else $error("wake halt too short");
endmodule : ctdsc_monitor
bind ctdsc_top ctdsc_monitor u_mon (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_trim(osc_trim),
  .trim_range_select(trim_range_select), .trim_fine_value(trim_fine_value), .sleep_instr(sleep_instr),
  .adc_enabled(adc_enabled), .cpu_clk_on(cpu_clk_on), .flash_clk_on(flash_clk_on), .io_clk_on(io_clk_on),
  .adc_clk_on(adc_clk_on), .osc_run(osc_run), .adc_start(adc_start), .wake_irq_go(wake_irq_go));
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  // Bench signals
  logic       clk, rst_b, reg_wr, reg_rd, sl, adc_en, xtal, trs, opt;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, ot, d;
  logic [6:0] tfv;
  logic [5:0] wk;
  logic       tick, cpu, fl, io, adc, osc, ast, go;
  int         fail_count, n_compared;
  ctdsc_top DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .factory_trim(8'h5A), .divide_by_eight_option(opt),
    .sleep_instr(sl), .adc_enabled(adc_en), .xtal_source(xtal), .irq_pending(wk[0]), .adc_done_irq(wk[1]),
    .mem_ready_irq(wk[2]), .wdt_irq(wk[3]), .ext_external_interrupt_zero_level(wk[4]), .pin_change(wk[5]), .osc_trim(ot),
    .trim_range_select(trs), .trim_fine_value(tfv), .sys_tick(tick), .cpu_clk_on(cpu), .flash_clk_on(fl),
    .io_clk_on(io), .adc_clk_on(adc), .osc_run(osc), .adc_start(ast), .wake_irq_go(go));
  ////////////////////////////////////////////////////////////////
  // Clock
  always #25 clk = ~clk;
  // Bus cycles: strobe set after one edge, dropped after the next
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk); reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge clk); reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk); reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task pulse();
    @(posedge clk); sl <= 1'b1;
    @(posedge clk); sl <= 1'b0;
  endtask : pulse
  // Tick spacing; third gap is clear of any factor change
  task per(output int n);
    repeat (3) begin
      n = 0;
      do begin @(negedge clk); n++; end while (tick !== 1'b1 && n < 600);
    end
  endtask : per
  task test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////
  // Scenarios
  task t_regs();
    rd(4'h0, d); `CHK("trim rst", 8'h5A, d)
    rd(4'h4, d); `CHK("div rst", 8'h03, d)
    rd(4'h2, d); `CHK("unmapped", 8'h00, d)
    wr(4'h0, 8'h7F); @(negedge clk); `CHK("lo range", 1'b0, trs)
    `CHK("fine max", 7'h7F, tfv)
    wr(4'h0, 8'h80); @(negedge clk); `CHK("hi range", 1'b1, trs)
    `CHK("fine min", 7'h00, tfv)
    `CHK("trim out", 8'h80, ot)
    rd(4'h0, d); `CHK("trim rd", 8'h80, d)
    $display("regs done");
  endtask : t_regs
  task t_unlock();
    wr(4'h4, 8'h02); rd(4'h4, d); `CHK("locked", 8'h03, d)
    wr(4'h4, 8'h81); wr(4'h4, 8'h02); rd(4'h4, d); `CHK("bad unlock", 8'h03, d)
    wr(4'h4, 8'h80); rd(4'h4, d); `CHK("unlocked", 8'h83, d)
    repeat (3) @(posedge clk);
    wr(4'h4, 8'h02); rd(4'h4, d); `CHK("expired", 8'h03, d)
    wr(4'h4, 8'h80); wr(4'h4, 8'h71); rd(4'h4, d); `CHK("rsvd bits", 8'h01, d)
    $display("unlock done");
  endtask : t_unlock
  task t_div();
    int n;
    for (int c = 0; c <= 9; c++) begin
      wr(4'h4, 8'h80); wr(4'h4, 8'(c)); per(n);
      `CHK("period", (c == 9) ? 256 : (1 << c), n)
    end
    rd(4'h4, d); `CHK("rsvd code", 8'h09, d)
    wr(4'h4, 8'h80); wr(4'h4, 8'h00);
    $display("divider done");
  endtask : t_div
  // g holds cpu, io, adc, osc during sleep
  task slp(input logic [1:0] k, input logic x, input logic a, input logic [3:0] g, input int bad, good, mi);
    int i;
    xtal <= x; wr(4'h8, {3'b001, k, 3'b000}); pulse();
    @(negedge clk); `CHK("adc start", a, ast)
    @(negedge clk); `CHK("gates", g, {cpu, io, adc, osc})
    rd(4'hC, d); `CHK("status", {3'h2, k, 3'h0}, d)
    if (bad >= 0) begin
      @(posedge clk); wk[bad] <= 1'b1;
      repeat (12) @(negedge clk); `CHK("no wake", 1'b0, cpu)
      @(posedge clk); wk[bad] <= 1'b0;
    end
    @(posedge clk); wk[good] <= 1'b1;
    i = 0;
    while (go !== 1'b1 && i < 30) begin @(negedge clk); i++; end
    `CHK("wake time", 1'b1, i >= mi && i <= mi + 5)
    `CHK("all on", 4'hF, {cpu, io, adc, osc})
    @(posedge clk); wk[good] <= 1'b0;
    $display("sleep kind %0d done", k);
  endtask : slp
  task t_misc();
    xtal <= 1'b0;
    wr(4'h8, 8'h10); pulse(); repeat (3) @(negedge clk); `CHK("unarmed", 1'b1, cpu)
    wr(4'h8, 8'h38); pulse(); repeat (2) @(negedge clk); `CHK("pd osc", 1'b0, osc)
    @(posedge clk); rst_b <= 1'b0; opt <= 1'b0;
    repeat (2) @(posedge clk); rst_b <= 1'b1;
    repeat (2) @(posedge clk); @(negedge clk);
    `CHK("reset wake", 4'hF, {cpu, io, adc, osc})
    rd(4'h0, d); `CHK("trim reload", 8'h5A, d)
    rd(4'h4, d); `CHK("div rst plain", 8'h00, d)
    $display("misc done");
  endtask : t_misc
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk = 0; rst_b = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
    sl = 0; adc_en = 1; xtal = 0; wk = 0; fail_count = 0; n_compared = 0; opt = 1;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs(); t_unlock(); t_div();
    slp(2'h0, 1'b0, 1'b1, 4'b0111, -1, 0, 5);
    adc_en <= 1'b0;
    slp(2'h0, 1'b0, 1'b0, 4'b0111, -1, 0, 5);
    adc_en <= 1'b1;
    slp(2'h1, 1'b0, 1'b1, 4'b0011, 0, 1, 5);
    slp(2'h2, 1'b0, 1'b0, 4'b0000, 2, 3, 11);
    slp(2'h3, 1'b1, 1'b0, 4'b0001, 1, 5, 7);
    t_misc();
    test_done();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
